// *** logic/adc_readout_host.v ***
/*
 * host-side sequencer for a 16-bit successive-approximation converter.
 * master mode: queued start (8 bits) and readout (16 bits) transfers with a
 * programmable delay after each, wrapping forever. slave mode: waits for the
 * end of busy on the select pin, then clocks in 16 bits from the converter's
 * own serial clock. assumes a 100 MHz clock and a plain register port.
 */
// The strobed register port and the register addresses were chosen for this implementation.
`include "adc_seq_regs.vh"
`default_nettype none

module adc_readout_host (
    input  wire        mclk_i,         // system clock, 100 MHz
    input  wire        reset_n_i,      // async reset, active low
    input  wire [3:0]  addr_i,         // register index
    input  wire [15:0] wdata_i,        // write data
    input  wire        wr_i,           // write strobe
    input  wire        rd_i,           // read strobe
    output reg  [15:0] rdata_o,        // read data, cycle after strobe
    output reg         sck_o,          // serial clock to converter
    output reg         host_periph_select_a_o, // read/convert select
    output reg         host_periph_select_b_o, // chip select
    input  wire        parallel_msb_pin_i,     // shared data line
    input  wire        slave_select_i, // busy pin in slave mode
    input  wire        ext_sck_i,      // converter clock in slave mode
    output reg         result_valid_o  // pulse when a result lands
);

    // one-hot sequencer states; slave mode has its own state so a change to
    // slave mode in mid-round waits for the master round to finish
    localparam [5:0] S_IDLE  = 6'b000001;
    localparam [5:0] S_START = 6'b000010;
    localparam [5:0] S_DLY1  = 6'b000100;
    localparam [5:0] S_READ  = 6'b001000;
    localparam [5:0] S_DLY2  = 6'b010000;
    localparam [5:0] S_SLAVE = 6'b100000;

    // control, status and datapath registers
    reg  [7:0]  ctrl;
    reg  [7:0]  delay_setting;
    reg  [5:0]  state;
    reg  [4:0]  bits_left;
    reg  [15:0] shifter;
    reg  [15:0] result;
    reg  [15:0] conv_count;
    reg  [23:0] delay_count;
    reg         valid;
    reg         overrun;
    reg         synced;
    reg         phase_high;
    reg         ss_seen_low;

    // synchronised pin views and decoded control bits
    wire        half;
    wire        data_s;
    wire        ss_s;
    wire        ss_rise;
    wire        ext_sck_s;
    wire        ext_fall;
    wire        run     = ctrl[`CTRL_RUN_BIT];
    wire        slave   = ctrl[`CTRL_SLAVE_BIT];
    wire        master_xfer = (state == S_START) | (state == S_READ);

    // delay length in system cycles for a given setting
    function [23:0] delay_cycles;
        input [7:0] setting;
        begin
            delay_cycles = {16'h0000, setting} * `DELAY_UNIT_CYCLES;
        end
    endfunction

    // link clock timing; the divider restarts with each transfer so every
    // frame opens with a full low half
    sck_divider u_div (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .run_i     (master_xfer),
        .half_o    (half)
    );

    // every converter pin passes two flops before any logic reads it; the
    // data view lags the pin by two cycles, well inside a 12-cycle half
    pin_sync u_data (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (parallel_msb_pin_i),
        .level_o   (data_s),
        .rise_o    (),
        .fall_o    ()
    );

    pin_sync u_ss (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (slave_select_i),
        .level_o   (ss_s),
        .rise_o    (ss_rise),
        .fall_o    ()
    );

    pin_sync u_esck (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (ext_sck_i),
        .level_o   (ext_sck_s),
        .rise_o    (),
        .fall_o    (ext_fall)
    );

    // register writes; clearing run drops the sequencer back to idle
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl          <= `CTRL_RESET;
            delay_setting <= `DELAY_SETTING_RESET;
        end else if (wr_i) begin
            case (addr_i)
                `REG_CTRL:  ctrl <= wdata_i[7:0];
                `REG_DELAY: begin
                    // a setting below 10 would squeeze the conversion;
                    // a refused write leaves the last legal value in place
                    if (wdata_i[7:0] >= `DELAY_SETTING_RESET)
                        delay_setting <= wdata_i[7:0];
                end
                default: ;
            endcase
        end
    end

    // read port: data stands in the cycle after the strobe only;
    // unmapped indices answer zero
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `REG_CTRL:     rdata_o <= {8'h00, ctrl};
                `REG_STATUS:   rdata_o <= {12'h000, synced, overrun, valid,
                                           state != S_IDLE};
                `REG_RESULT:   rdata_o <= result;
                `REG_DELAY:    rdata_o <= {8'h00, delay_setting};
                `REG_COUNT:    rdata_o <= conv_count;
                `REG_CMDBYTES: rdata_o <= {`CMD_READ, `CMD_START};
                default:       rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // queue sequencer; the delay covers the busy window so the link stays
    // still while the converter decides its bits
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state                  <= S_IDLE;
            bits_left              <= 5'd0;
            shifter                <= 16'h0000;
            result                 <= 16'h0000;
            conv_count             <= 16'h0000;
            delay_count            <= 24'h000000;
            valid                  <= 1'b0;
            overrun                <= 1'b0;
            synced                 <= 1'b0;
            phase_high             <= 1'b0;
            ss_seen_low            <= 1'b0;
            sck_o                  <= 1'b0;
            host_periph_select_a_o <= 1'b1;
            host_periph_select_b_o <= 1'b1;
            result_valid_o         <= 1'b0;
        end else begin
            // the result pulse lasts one cycle
            result_valid_o <= 1'b0;
            // status read clears valid and overrun; a new result wins
            if (rd_i && addr_i == `REG_STATUS) begin
                valid   <= 1'b0;
                overrun <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    sck_o                  <= 1'b0;
                    host_periph_select_a_o <= 1'b1;
                    host_periph_select_b_o <= 1'b1;
                    synced                 <= 1'b0;
                    phase_high             <= 1'b0;
                    ss_seen_low            <= 1'b0;
                    if (run && slave) begin
                        state <= S_SLAVE;
                    end else if (run) begin
                        // both selects low starts the conversion
                        host_periph_select_a_o <= 1'b0;
                        host_periph_select_b_o <= 1'b0;
                        bits_left              <= `START_BITS;
                        state                  <= S_START;
                    end
                end
                // a transfer ends on its last falling half: the selects rise
                // with the clock, so no clock edge falls outside a frame
                S_START, S_READ: begin
                    if (half) begin
                        phase_high <= ~phase_high;
                        sck_o      <= ~phase_high;
                        if (!phase_high) begin
                            // rising edge captures, msb first
                            shifter <= {shifter[14:0], data_s};
                        end else if (bits_left == 5'd1) begin
                            host_periph_select_a_o <= 1'b1;
                            host_periph_select_b_o <= 1'b1;
                            delay_count <= delay_cycles(delay_setting);
                            state <= (state == S_START) ? S_DLY1 : S_DLY2;
                            if (state == S_READ) begin
                                result         <= shifter;
                                overrun        <= overrun | valid;
                                valid          <= 1'b1;
                                result_valid_o <= 1'b1;
                                conv_count     <= conv_count + 16'h0001;
                            end
                        end else begin
                            bits_left <= bits_left - 5'd1;
                        end
                    end
                end
                S_DLY1: begin
                    // converter is busy: pins stay still here
                    if (delay_count <= 24'h000001) begin
                        host_periph_select_b_o <= 1'b0;
                        bits_left              <= `READ_BITS;
                        state                  <= S_READ;
                    end else begin
                        delay_count <= delay_count - 24'h000001;
                    end
                end
                // delay after the readout, then wrap on the crystal timing;
                // a cleared run stops here, never mid-round; one-shot only passes through idle, which starts again while run is set
                S_DLY2: begin
                    if (delay_count <= 24'h000001) begin
                        if (run && !ctrl[`CTRL_ONESHOT_BIT] && !slave) begin
                            host_periph_select_a_o <= 1'b0;
                            host_periph_select_b_o <= 1'b0;
                            bits_left              <= `START_BITS;
                            state                  <= S_START;
                        end else begin
                            state <= S_IDLE;
                        end
                    end else begin
                        delay_count <= delay_count - 24'h000001;
                    end
                end
                // slave: the converter drives the clock, the host only listens
                S_SLAVE: begin
                    if (!run || !slave) begin
                        state <= S_IDLE;
                    end else if (!synced) begin
                        // the synchroniser leaves reset low, so a pin already
                        // high would fake an end of conversion; a rise only
                        // counts once busy has been seen low in this state
                        if (!ss_s)
                            ss_seen_low <= 1'b1;
                        // arm only at the end of a conversion
                        if (ss_rise && ss_seen_low) begin
                            synced      <= 1'b1;
                            ss_seen_low <= 1'b0;
                            bits_left   <= `READ_BITS;
                        end
                    end else if (ext_fall) begin
                        // data valid on the falling edge of an idle-low clock
                        shifter <= {shifter[14:0], data_s};
                        if (bits_left == 5'd1) begin
                            result         <= {shifter[14:0], data_s};
                            overrun        <= overrun | valid;
                            valid          <= 1'b1;
                            result_valid_o <= 1'b1;
                            conv_count     <= conv_count + 16'h0001;
                            bits_left      <= `READ_BITS;
                            synced         <= 1'b0;
                        end else begin
                            bits_left <= bits_left - 5'd1;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** logic/adc_seq_regs.vh ***
/*
 * constants for the converter readout sequencer: register offsets, field
 * positions, reset values, command bytes and timing counts.
 * assumes a 100 MHz system clock; included by the sequencer design files and the testbench.
 */
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// register offsets (word index on the plain command port)
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define REG_RESULT          4'h2
`define REG_DELAY           4'h3
`define REG_COUNT           4'h4
`define REG_CMDBYTES        4'h5
// control fields
`define CTRL_RUN_BIT        0
`define CTRL_SLAVE_BIT      1
`define CTRL_ONESHOT_BIT    2
`define CTRL_RESET          8'h00
// status fields
`define ST_BUSY_BIT         0
`define ST_VALID_BIT        1
`define ST_OVERRUN_BIT      2
`define ST_SYNCED_BIT       3
// command control bytes of the two queued transfers
`define CMD_START           8'h20
`define CMD_READ            8'h61
// transfer lengths
`define START_BITS          5'h08
`define READ_BITS           5'h10
// serial clock: 100 MHz / 24 = 4.17 MHz, nearest even split to 4.19 MHz
`define SCK_FREQ_KHZ        4190
`define CLK_FREQ_KHZ        100000
`define SCK_HALF_CYCLES     8'h0C
// delay after transfer: 19 us, setting of 10 gives the fastest rate
`define DELAY_AFTER_US      19
`define DELAY_SETTING_RESET 8'h0A
`define DELAY_UNIT_CYCLES   24'h0000BE  // 1.9 us per setting step at 100 MHz
`define QUIET_AFTER_US      8
`define QUIET_CYCLES        (`QUIET_AFTER_US * 100)

`endif

// *** logic/pin_sync.v ***
/*
 * two-stage synchroniser for pins from outside the clock domain, with a
 * registered copy for edge finding. assumes nothing of the pin's timing.
 */
`include "adc_seq_regs.vh"
`default_nettype none

module pin_sync (
    input  wire       mclk_i,     // system clock
    input  wire       reset_n_i,  // async reset, active low
    input  wire       pin_i,      // asynchronous pin
    output reg        level_o,    // synchronised level
    output wire       rise_o,     // one-cycle pulse on low-to-high
    output wire       fall_o      // one-cycle pulse on high-to-low
);

    reg meta;
    reg prev;

    // first flop feeds only the second
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta    <= 1'b0;
            level_o <= 1'b0;
            prev    <= 1'b0;
        end else begin
            meta    <= pin_i;
            level_o <= meta;
            prev    <= level_o;
        end
    end

    assign rise_o = level_o & ~prev;
    assign fall_o = ~level_o & prev;

endmodule
`default_nettype wire

// *** logic/sck_divider.v ***
/*
 * serial clock divider: one-cycle enable pulses at each half period of the
 * link clock. assumes a single 100 MHz clock and a synchronous run level.
 */
`include "adc_seq_regs.vh"
`default_nettype none

module sck_divider (
    input  wire       mclk_i,     // system clock
    input  wire       reset_n_i,  // async reset, active low
    input  wire       run_i,      // count while high, restart when low
    output reg        half_o      // one-cycle pulse per half period
);

    reg [7:0] count;

    // restart on every idle so the first half period is full length
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count  <= 8'h00;
            half_o <= 1'b0;
        end else if (!run_i) begin
            count  <= 8'h00;
            half_o <= 1'b0;
        end else if (count == `SCK_HALF_CYCLES - 8'h01) begin
            count  <= 8'h00;
            half_o <= 1'b1;
        end else begin
            count  <= count + 8'h01;
            half_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** verification/adc_readout_host_properties.sv ***
/* checker: frame shape, link clock shape and register port of the sequencer.
   assumes a bind onto adc_readout_host with the delay setting at 10. */
`default_nettype none
module adc_readout_host_properties (
    input wire logic        mclk_i,                 // clock
    input wire logic        reset_n_i,              // reset, low
    input wire logic        rd_i,                   // read strobe
    input wire logic [15:0] rdata_o,                // read data
    input wire logic        sck_o,                  // link clock
    input wire logic        host_periph_select_a_o, // convert select
    input wire logic        host_periph_select_b_o, // chip select
    input wire logic        result_valid_o          // result pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP_MIN = 1900;
    int   rises;
    int   gap;
    logic start;
    // clock rises per frame, idle cycles between frames, kind of frame
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rises <= 0;
            // no frame precedes the first, so it may open at once
            gap   <= GAP_MIN;
            start <= 1'b0;
        end else if (host_periph_select_b_o) begin
            rises <= 0;
            gap   <= gap + 1;
        end else begin
            gap   <= 0;
            start <= !host_periph_select_a_o;
            if ($rose(sck_o))
                rises <= rises + 1;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence hi_half;
        sck_o [*8] ##1 sck_o [*4];
    endsequence
    sequence lo_half;
        !sck_o [*8] ##1 !sck_o [*4];
    endsequence
    a_sck_idle_low: assert property (host_periph_select_b_o |-> !sck_o)
        else $error("link clock high outside a frame");
    a_sck_high_half: assert property ($rose(sck_o) |-> hi_half ##1 !sck_o)
        else $error("link clock high half not 12 cycles");
    a_sck_low_half: assert property ($fell(sck_o) && !host_periph_select_b_o |-> lo_half ##1 sck_o)
        else $error("link clock low half not 12 cycles");
    a_start_both_low: assert property ($fell(host_periph_select_a_o) |-> $fell(host_periph_select_b_o))
        else $error("start frame without both selects falling");
    a_convert_inside_cs: assert property (!host_periph_select_a_o |-> !host_periph_select_b_o)
        else $error("convert select low without chip select");
    a_frame_bit_count: assert property ($rose(host_periph_select_b_o) |-> rises == (start ? 8 : 16))
        else $error("frame clock count wrong");
    a_delay_after_frame: assert property ($fell(host_periph_select_b_o) |-> gap >= GAP_MIN)
        else $error("frame gap shorter than the delay");
    a_valid_after_read: assert property ($rose(host_periph_select_b_o) && !start |-> ##[0:3] result_valid_o)
        else $error("no result after readout frame");
    a_valid_one_cycle: assert property (result_valid_o |=> !result_valid_o)
        else $error("result pulse longer than one cycle");
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside the answer cycle");
endmodule
bind adc_readout_host adc_readout_host_properties chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_o(sck_o),
    .host_periph_select_a_o(host_periph_select_a_o),
    .host_periph_select_b_o(host_periph_select_b_o), .result_valid_o(result_valid_o));
`default_nettype wire

// *** verification/adc_readout_host_tb_top.sv ***
/* testbench: register port, one-shot and wrapped rounds, slave mode.
   assumes the converter model beside the design and a 100 MHz clock. */
`include "adc_seq_regs.vh"
`default_nettype none
module adc_readout_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic        sck, sel_a, sel_b, pin, busy, esck, valid;
    int          miscompares = 0, compares = 0, cycles = 0;
    adc_readout_host dut (.mclk_i(mclk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sck_o(sck), .host_periph_select_a_o(sel_a),
        .host_periph_select_b_o(sel_b), .parallel_msb_pin_i(pin), .slave_select_i(busy),
        .ext_sck_i(esck), .result_valid_o(valid));
    sar_converter_model conv (.sck_i(sck), .sel_a_i(sel_a), .sel_b_i(sel_b), .msb_pin_o(pin),
        .busy_o(busy), .ext_sck_o(esck));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // answer stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask
    task automatic wait_valid();
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 8000) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({15'h0, valid}, 16'h0001);
    endtask
    task automatic t_regs();
        chk({14'h0, sel_a, sel_b, sck}, 16'h0006);
        rd_chk(`REG_CTRL, 16'h0000, 16'h00FF);
        rd_chk(`REG_DELAY, 16'h000A, 16'h00FF);
        rd_chk(`REG_CMDBYTES, 16'h6120, 16'hFFFF);
        rd_chk(4'hF, 16'h0000, 16'hFFFF);
        wr_reg(`REG_DELAY, 16'h0005);
        rd_chk(`REG_DELAY, 16'h000A, 16'h00FF);
        wr_reg(`REG_DELAY, 16'h000C);
        rd_chk(`REG_DELAY, 16'h000C, 16'h00FF);
        wr_reg(`REG_DELAY, 16'h000A);
        $display("test regs done");
    endtask
    task automatic t_oneshot();
        conv.vin = 16'hA5C3;
        wr_reg(`REG_CTRL, 16'h0005); // run and one-shot
        wait_valid();
        rd_chk(`REG_RESULT, 16'hA5C3, 16'hFFFF);
        rd_chk(`REG_STATUS, 16'h0002, 16'h0002);
        chk(conv.faults[15:0], 16'h0000);
        $display("test oneshot done");
    endtask
    task automatic t_wrap();
        conv.vin = 16'h0001;
        wr_reg(`REG_CTRL, 16'h0001);
        wait_valid();
        rd_chk(`REG_RESULT, 16'h0001, 16'hFFFF);
        conv.vin = 16'hFFFE;
        wait_valid();
        rd_chk(`REG_RESULT, 16'hFFFE, 16'hFFFF);
        wr_reg(`REG_CTRL, 16'h0000);
        repeat (2500) @(posedge mclk);
        // idle, two unread results: valid and overrun both stand
        rd_chk(`REG_STATUS, 16'h0006, 16'h000F);
        rd_chk(`REG_COUNT, 16'h0003, 16'hFFFF);
        chk(conv.faults[15:0], 16'h0000);
        $display("test wrap done");
    endtask
    // stray clocks during busy must not shift anything in
    task automatic t_slave();
        wr_reg(`REG_CTRL, 16'h0003);
        conv.slave_frame(16'h3C5A, 3);
        repeat (4) @(posedge mclk);
        rd_chk(`REG_STATUS, 16'h0002, 16'h000E);
        rd_chk(`REG_RESULT, 16'h3C5A, 16'hFFFF);
        rd_chk(`REG_COUNT, 16'h0004, 16'hFFFF);
        $display("test slave done");
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_oneshot();
        t_wrap();
        t_slave();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verification/sar_converter_model.sv ***
/* behavioural converter: ideal approximation, serial result on the shared
   line, own clock and busy for the slave setup. assumes a host on the selects. */
`default_nettype none
module sar_converter_model (
    input  wire logic sck_i,     // link clock from host
    input  wire logic sel_a_i,   // read/convert select
    input  wire logic sel_b_i,   // chip select
    output var  logic msb_pin_o, // shared data line
    output var  logic busy_o,    // busy, high when idle
    output var  logic ext_sck_o  // own clock, slave setup
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] vin;
    logic [15:0] code;
    logic [15:0] sh;
    logic        quiet;
    logic        slv;
    int          faults;
    initial begin
        {vin, code, sh} = 48'h0;
        {quiet, slv, busy_o, ext_sck_o} = 4'b0010;
        faults = 0;
    end
    // released line shows the inverse, never a stale copy
    assign msb_pin_o = (slv || (!sel_b_i && sel_a_i)) ? sh[15] : ~sh[15];
    task automatic convert();
        logic [15:0] trial;
        busy_o = 1'b0;
        code = 16'h0000;
        fork
            #8000 quiet = 1'b1;
            // ideal decisions leave the tenth-step repair nothing to fix
            for (int i = 15; i >= 0; i--) begin
                #1050; // tenth decision lands 10.5 us in
                trial = code | (16'h0001 << i);
                if (trial <= vin) code = trial;
            end
        join
        quiet = 1'b0;
        busy_o = 1'b1;
    endtask
    // selects settle in one step, so look after they land
    always @(negedge sel_b_i) begin
        #1;
        if (!sel_a_i) convert();
        else sh = code;
    end
    always @(negedge sck_i) sh = {sh[14:0], 1'b0};
    // host pin edges inside the quiet span are counted
    always @(sck_i or sel_a_i or sel_b_i) if (quiet) faults++;
    task automatic slave_frame(input logic [15:0] v, input int pre);
        busy_o = 1'b0;
        for (int i = 0; i < pre; i++) begin
            #80 ext_sck_o = 1'b1;
            #80 ext_sck_o = 1'b0;
        end
        #2000 sh = v;
        slv = 1'b1;
        busy_o = 1'b1;
        for (int i = 0; i < 16; i++) begin
            #80 ext_sck_o = 1'b1; // data moves on the rise
            if (i != 0) sh = {sh[14:0], 1'b0};
            #80 ext_sck_o = 1'b0;
        end
        #80 slv = 1'b0;
    endtask
endmodule
`default_nettype wire
